// ===== common/tsm_pkg.sv
// constants, states and carriers shared by the measurement sequencer
package tsm_pkg;
  // clock and conversion timing (times in ns)
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_CONV_INT_NS = 712000;
  localparam int T_CONV_EXT_NS = 1510000;
  localparam int CONV_INT_CYC  = (T_CONV_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_EXT_CYC  = (T_CONV_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AVG_SAMPLES_DEF = 16;
  // register offsets
  localparam logic [7:0] ADDR_IRQ_TEMP  = 8'h00;
  localparam logic [7:0] ADDR_INT_SUP_LO = 8'h03;
  localparam logic [7:0] ADDR_EXT_LO    = 8'h04;
  localparam logic [7:0] ADDR_SUP_HI    = 8'h06;
  localparam logic [7:0] ADDR_INT_HI    = 8'h07;
  localparam logic [7:0] ADDR_EXT_HI    = 8'h08;
  localparam logic [7:0] ADDR_IRQ_SUP   = 8'h10;
  localparam logic [7:0] ADDR_MEAS_CTRL = 8'h19;
  // measurement_control fields and reset value
  localparam int CTRL_SEL_BIT0  = 0;
  localparam int CTRL_SEL_BIT1  = 1;
  localparam int CTRL_SINGLE    = 4;
  localparam int CTRL_AVG_OFF   = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // low-bit positions inside the shared low-bits registers
  localparam int SUP_LSB_POS = 0;
  localparam int INT_LSB_POS = 6;
  localparam int EXT_LSB_POS = 6;
  // flag positions
  localparam int FLG_INT_HIGH = 0;
  localparam int FLG_INT_LOW  = 1;
  localparam int FLG_EXT_HIGH = 2;
  localparam int FLG_EXT_LOW  = 3;
  localparam int FLG_SUP_HIGH = 0;
  localparam int FLG_SUP_LOW  = 1;
  // mask bit positions
  localparam int MSK_INT = 0;
  localparam int MSK_EXT = 1;
  localparam int MSK_SUP = 2;
  // +127 degrees in quarter-degree steps
  localparam logic signed [11:0] TEMP_SAT_Q = 12'h1FC;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CONV  = 2'b01,
    ST_STORE = 2'b10
  } tsm_state_type;

  typedef enum logic [1:0] {
    CH_SUPPLY = 2'b00,
    CH_INT    = 2'b01,
    CH_EXT    = 2'b10
  } tsm_chan_type;

  typedef struct packed {
    logic [9:0] high;
    logic [9:0] low;
  } tsm_limits_type;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsm_reg_req_type;
endpackage

// ===== sim/tb.sv
// bench for the measurement sequencer: register reads, modes, limits, abort
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb;
  import tsm_pkg::*;
  logic clk, rst, serial_busy, monitor_en, alert_active_high, tvo_ten_bit, adc_sample;
  logic adc_reset, alert;
  tsm_reg_req_type req;          // register request
  logic [7:0]  reg_rdata, int_off, ext_off;
  logic [2:0]  irq_mask;
  logic [1:0]  tvo_enable, adc_chan, dac_update;
  logic [9:0]  adc_data, dac_int_code, dac_ext_code, sup_val, int_val, ext_val;
  tsm_limits_type int_lim, ext_lim, sup_lim;
  int n_errors, checks_done, cycles;
  int n_pulses;                  // pulses counted over a window

  tsm_sequencer #(.CONV_INT_CYCLES(4), .CONV_EXT_CYCLES(6), .AVG_SAMPLES(16)) tsm_sequencer_i (
    .clk(clk), .rst(rst), .reg_req(req), .reg_rdata(reg_rdata), .serial_busy(serial_busy),
    .monitor_en(monitor_en), .alert_active_high(alert_active_high), .irq_mask(irq_mask),
    .int_limits(int_lim), .ext_limits(ext_lim), .sup_limits(sup_lim),
    .tvo_enable(tvo_enable), .tvo_ten_bit(tvo_ten_bit), .int_tvo_offset(int_off),
    .ext_tvo_offset(ext_off), .adc_data(adc_data), .adc_chan(adc_chan),
    .adc_sample(adc_sample), .adc_reset(adc_reset), .alert(alert),
    .dac_int_code(dac_int_code), .dac_ext_code(dac_ext_code), .dac_update(dac_update));

  tsm_adc_model tsm_adc_model_i (.adc_chan(adc_chan), .adc_reset(adc_reset),
    .sup_val(sup_val), .int_val(int_val), .ext_val(ext_val), .adc_data(adc_data));

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      test_done();
    end
  end

  // verdict
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one register read, data checked the cycle after the request
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    `CHK("reg_rdata", ex, reg_rdata)
  endtask

  // one register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // main sequence
  initial begin
    n_errors = 0; checks_done = 0; cycles = 0;
    rst = 1'b1; req = '0; serial_busy = 1'b0; monitor_en = 1'b0;
    alert_active_high = 1'b0; irq_mask = 3'b000; tvo_enable = 2'b11; tvo_ten_bit = 1'b0;
    int_off = 8'h00;
    ext_off = 8'hD8;
    sup_val = 10'h2DB; int_val = 10'h065; ext_val = 10'h3A1;
    int_lim = {10'h064, 10'h200}; ext_lim = {10'h1FC, 10'h3A0}; sup_lim = {10'h3FF, 10'h101};
    repeat (4) @(negedge clk);
    rst = 1'b0;
    rd(ADDR_MEAS_CTRL, 8'h00);
    // no flags with an active-low setting: alert rests high
    `CHK("alert", 1'b1, alert)
    alert_active_high = 1'b1;
    // round robin over all three channels
    monitor_en = 1'b1;
    repeat (500) @(negedge clk);
    `CHK("alert", 1'b1, alert)
    rd(ADDR_SUP_HI, 8'hB6);
    rd(8'h55, 8'h00);
    rd(ADDR_INT_SUP_LO, 8'h43);
    rd(ADDR_INT_HI, 8'h19);
    rd(ADDR_EXT_HI, 8'hE8);
    rd(ADDR_EXT_LO, 8'h40);
    rd(ADDR_IRQ_SUP, 8'h00);
    rd(ADDR_IRQ_TEMP, 8'h01);
    `CHK("dac_int_code", 10'h019, dac_int_code)
    `CHK("dac_ext_code", 10'h010, dac_ext_code)
    // masked temperature flags stay clear
    irq_mask = 3'b001;
    repeat (300) @(negedge clk);
    rd(ADDR_IRQ_TEMP, 8'h00);
    `CHK("alert", 1'b0, alert)
    // single channel on the supply, averaging off, below the low limit
    wr(ADDR_MEAS_CTRL, 8'h30);
    sup_val = 10'h100;
    repeat (400) @(negedge clk);
    n_pulses = 0;
    repeat (60) begin
      @(negedge clk);
      `CHK("adc_chan", 2'b00, adc_chan)
      n_pulses += int'(adc_sample);
    end
    // one sample and one store per five cycles without averaging
    `CHK("adc_sample pulses", 12, n_pulses)
    rd(ADDR_SUP_HI, 8'h40);
    // supply flag set: active-low polarity pulls alert low
    alert_active_high = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("alert", 1'b0, alert)
    alert_active_high = 1'b1;
    rd(ADDR_IRQ_SUP, 8'h02);
    // serial activity aborts, then conversion restarts
    serial_busy = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("adc_reset", 1'b1, adc_reset)
    serial_busy = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("adc_reset", 1'b0, adc_reset)
    `CHK("adc_chan", 2'b00, adc_chan)
    // single internal channel at the top of the range
    irq_mask = 3'b101;
    wr(ADDR_MEAS_CTRL, 8'h31);
    int_val = 10'h1FF;
    tvo_ten_bit = 1'b1;
    repeat (240) @(negedge clk);
    n_pulses = 0;
    repeat (60) begin
      @(negedge clk);
      n_pulses += int'(dac_update[0]) + 2 * int'(dac_update[1]);
    end
    // internal code refreshed once per store, external never
    `CHK("dac_update pulses", 12, n_pulses)
    `CHK("adc_chan", 2'b01, adc_chan)
    `CHK("dac_int_code", 10'h1FC, dac_int_code)
    rd(ADDR_INT_HI, 8'h7F);
    // single external channel, averaging on, ten bit thermal code
    wr(ADDR_MEAS_CTRL, 8'h12);
    ext_val = 10'h0CA;
    repeat (300) @(negedge clk);
    `CHK("adc_chan", 2'b10, adc_chan)
    rd(ADDR_EXT_HI, 8'h32);
    rd(ADDR_EXT_LO, 8'h80);
    `CHK("dac_ext_code", 10'h16A, dac_ext_code)
    // dropping the enable parks the converter in reset
    monitor_en = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("adc_reset", 1'b1, adc_reset)
    test_done();
  end
endmodule // tb
`undef CHK
`default_nettype wire

// ===== sim/tsm_adc_model.sv
// converter model: returns a fixed code for the channel being converted
`timescale 1ns/1ns
`default_nettype none
module tsm_adc_model
  import tsm_pkg::*;
(
  // sequencer side
  input  wire logic [1:0] adc_chan,
  input  wire logic       adc_reset,
  // codes chosen by the bench
  input  wire logic [9:0] sup_val,
  input  wire logic [9:0] int_val,
  input  wire logic [9:0] ext_val,
  // result
  output logic      [9:0] adc_data
);
  logic [9:0] sel_val; // code of the selected channel

  // channel mux; a converter in reset shows the inverse, never a stale code
  always_comb begin
    case (adc_chan)
      CH_SUPPLY: sel_val = sup_val;
      CH_INT:    sel_val = int_val;
      default:   sel_val = ext_val;
    endcase
    adc_data = adc_reset ? ~sel_val : sel_val;
  end
endmodule // tsm_adc_model
`default_nettype wire

// ===== src/tsm_limit_cmp.sv
// window comparator: result against high and low limits
`timescale 1ns/1ns
`default_nettype none
module tsm_limit_cmp
  import tsm_pkg::*;
(
  // operands
  input  wire logic           [9:0] value,
  input  wire tsm_limits_type       limits,
  input  wire logic                 is_signed,
  // results
  output logic                      above,
  output logic                      below
);
  // strictly outside the window counts as out of limit
  always_comb begin
    if (is_signed) begin
      above = $signed(value) > $signed(limits.high);
      below = $signed(value) < $signed(limits.low);
    end else begin
      above = value > limits.high;
      below = value < limits.low;
    end
  end
endmodule // tsm_limit_cmp
`default_nettype wire

// ===== src/tsm_sequencer.sv
// measurement sequencer: channel stepping, averaging, limits, thermal output
`timescale 1ns/1ns
`default_nettype none
module tsm_sequencer
  import tsm_pkg::*;
#(
  parameter int CONV_INT_CYCLES = CONV_INT_CYC,
  parameter int CONV_EXT_CYCLES = CONV_EXT_CYC,
  parameter int AVG_SAMPLES     = AVG_SAMPLES_DEF
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // register port
  input  wire tsm_reg_req_type       reg_req,
  output logic               [7:0]   reg_rdata,
  // serial transfer in progress
  input  wire logic                  serial_busy,
  // loose configuration
  input  wire logic                  monitor_en,
  input  wire logic                  alert_active_high,
  input  wire logic          [2:0]   irq_mask,
  input  wire tsm_limits_type        int_limits,
  input  wire tsm_limits_type        ext_limits,
  input  wire tsm_limits_type        sup_limits,
  // thermal voltage output setup
  input  wire logic          [1:0]   tvo_enable,
  input  wire logic                  tvo_ten_bit,
  input  wire logic          [7:0]   int_tvo_offset,
  input  wire logic          [7:0]   ext_tvo_offset,
  // converter
  input  wire logic          [9:0]   adc_data,
  output logic               [1:0]   adc_chan,
  output logic                       adc_sample,
  output logic                       adc_reset,
  // outputs
  output logic                       alert,
  output logic               [9:0]   dac_int_code,
  output logic               [9:0]   dac_ext_code,
  output logic               [1:0]   dac_update
);
  localparam int AVG_LOG2 = $clog2(AVG_SAMPLES);
  localparam int ACC_W    = 10 + AVG_LOG2;
  localparam int CNT_W    = $clog2(CONV_EXT_CYCLES > CONV_INT_CYCLES ?
                                   CONV_EXT_CYCLES : CONV_INT_CYCLES) + 1;

  if (AVG_SAMPLES < 2 || AVG_SAMPLES > 64 || (AVG_SAMPLES & (AVG_SAMPLES - 1)) != 0 ||
      CONV_INT_CYCLES < 1 || CONV_EXT_CYCLES < 1) begin : g_bad_param
    $error("tsm_sequencer: unsupported parameter values");
  end

  // selected single channel from the select bits
  function automatic logic [1:0] sel_chan(input logic [7:0] ctrl);
    sel_chan = ctrl[CTRL_SEL_BIT1] ? 2'(CH_EXT) : {1'b0, ctrl[CTRL_SEL_BIT0]};
  endfunction

  // temperature to thermal output code
  function automatic logic [9:0] tvo_map(input logic [9:0] t, input logic [7:0] off,
                                         input logic ten);
    logic signed [11:0] tc;
    logic signed [11:0] d;
    tc = {{2{t[9]}}, t};
    if (tc > TEMP_SAT_Q) tc = TEMP_SAT_Q;
    d = tc - {{2{off[7]}}, off, 2'b00};
    if (d < 0) tvo_map = 10'h000;
    else if (ten) tvo_map = d[9:0];
    else tvo_map = {2'b00, d[9:2]};
  endfunction

  // sequencer state
  tsm_state_type            state, next_state;
  logic [1:0]               chan, next_chan;               // channel in conversion
  logic [CNT_W-1:0]         cnt, next_cnt;                 // cycles within a conversion
  logic [AVG_LOG2-1:0]      nsamp, next_nsamp;             // samples taken so far
  logic signed [ACC_W-1:0]  acc, next_acc;                 // running sum
  logic [9:0]               result, next_result;           // averaged value to store
  logic                     sample_q, next_sample_q;
  // registers and outputs
  logic [7:0]               ctrl, next_ctrl;               // measurement_control
  logic [7:0]               irq_temp, next_irq_temp;       // irq_flags_temperature
  logic [7:0]               irq_sup, next_irq_sup;         // irq_flags_supply
  logic [7:0]               low_is, next_low_is;           // internal_temp_supply_low_bits
  logic [7:0]               low_ext, next_low_ext;
  logic [7:0]               sup_hi, next_sup_hi;           // supply_value_high_bits
  logic [7:0]               int_hi, next_int_hi;
  logic [7:0]               ext_hi, next_ext_hi;
  logic [7:0]               next_rdata;
  logic                     next_alert;
  logic [9:0]               next_dac_int, next_dac_ext;
  logic [1:0]               next_dac_upd;
  // datapath helpers
  logic [CNT_W-1:0]         conv_last_cnt;
  logic signed [ACC_W-1:0]  sample_ext;
  logic signed [ACC_W-1:0]  sum_now;
  logic                     samp_last;
  tsm_limits_type           cur_limits;
  logic                     is_above, is_below;

  // limits of the channel just measured
  always_comb begin
    if (chan == CH_INT) cur_limits = int_limits;
    else if (chan == CH_EXT) cur_limits = ext_limits;
    else cur_limits = sup_limits;
  end

  tsm_limit_cmp u_cmp (
    .value     (result),
    .limits    (cur_limits),
    .is_signed (chan != CH_SUPPLY),
    .above     (is_above),
    .below     (is_below)
  );

  // conversion length per channel
  assign conv_last_cnt = (chan == CH_EXT) ? CNT_W'(CONV_EXT_CYCLES - 1)
                                          : CNT_W'(CONV_INT_CYCLES - 1);
  // temperatures sign-extend, supply is unsigned
  assign sample_ext = (chan == CH_SUPPLY) ? ACC_W'({1'b0, adc_data})
                                          : ACC_W'($signed(adc_data));
  assign sum_now    = acc + sample_ext;
  assign samp_last  = ctrl[CTRL_AVG_OFF] || (nsamp == AVG_LOG2'(AVG_SAMPLES - 1));

  // sequencer next state
  always_comb begin
    next_state    = state;
    next_chan     = chan;
    next_cnt      = cnt;
    next_nsamp    = nsamp;
    next_acc      = acc;
    next_result   = result;
    next_sample_q = 1'b0;
    case (state)
      ST_IDLE: begin
        // start on the proper channel
        next_chan  = ctrl[CTRL_SINGLE] ? sel_chan(ctrl) : 2'(CH_SUPPLY);
        next_cnt   = '0;
        next_nsamp = '0;
        next_acc   = '0;
        if (monitor_en) next_state = ST_CONV;
      end
      ST_CONV: begin
        if (cnt == conv_last_cnt) begin
          // one conversion done: accumulate
          next_sample_q = 1'b1;
          next_cnt      = '0;
          if (samp_last) begin
            next_result = ctrl[CTRL_AVG_OFF] ? adc_data : sum_now[AVG_LOG2 +: 10];
            next_state  = ST_STORE;
          end else begin
            next_acc   = sum_now;
            next_nsamp = nsamp + 1'b1;
          end
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      ST_STORE: begin
        // choose the next channel and start again
        next_acc   = '0;
        next_nsamp = '0;
        next_cnt   = '0;
        next_state = monitor_en ? ST_CONV : ST_IDLE;
        if (ctrl[CTRL_SINGLE]) next_chan = sel_chan(ctrl);
        else if (chan == CH_SUPPLY) next_chan = CH_INT;
        else if (chan == CH_INT) next_chan = CH_EXT;
        else next_chan = CH_SUPPLY;
      end
      default: next_state = ST_IDLE;
    endcase
    // serial activity aborts whatever runs
    if (serial_busy || !monitor_en) next_state = ST_IDLE;
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= ST_IDLE;
      chan     <= CH_SUPPLY;
      cnt      <= '0;
      nsamp    <= '0;
      acc      <= '0;
      result   <= 10'h000;
      sample_q <= 1'b0;
    end else begin
      state    <= next_state;
      chan     <= next_chan;
      cnt      <= next_cnt;
      nsamp    <= next_nsamp;
      acc      <= next_acc;
      result   <= next_result;
      sample_q <= next_sample_q;
    end
  end

  // register file, flags, alert and thermal output
  always_comb begin
    logic store_ok;
    store_ok     = (state == ST_STORE) && !serial_busy;
    next_ctrl    = ctrl;
    next_irq_temp = irq_temp;
    next_irq_sup = irq_sup;
    next_low_is  = low_is;
    next_low_ext = low_ext;
    next_sup_hi  = sup_hi;
    next_int_hi  = int_hi;
    next_ext_hi  = ext_hi;
    next_dac_int = dac_int_code;
    next_dac_ext = dac_ext_code;
    next_dac_upd = 2'b00;
    next_rdata   = reg_rdata;
    // software write
    if (reg_req.wr && reg_req.addr == ADDR_MEAS_CTRL) next_ctrl = reg_req.wdata;
    // read clears a flag register before new events land
    if (reg_req.rd && reg_req.addr == ADDR_IRQ_TEMP) next_irq_temp = 8'h00;
    if (reg_req.rd && reg_req.addr == ADDR_IRQ_SUP) next_irq_sup = 8'h00;
    // store one result: all its bytes in this cycle
    if (store_ok) begin
      if (chan == CH_SUPPLY) begin
        next_low_is[SUP_LSB_POS +: 2] = result[1:0];
        next_sup_hi = result[9:2];
        if (!irq_mask[MSK_SUP]) begin
          if (is_above) next_irq_sup[FLG_SUP_HIGH] = 1'b1;
          if (is_below) next_irq_sup[FLG_SUP_LOW] = 1'b1;
        end
      end else if (chan == CH_INT) begin
        next_low_is[INT_LSB_POS +: 2] = result[1:0];
        next_int_hi = result[9:2];
        if (!irq_mask[MSK_INT]) begin
          if (is_above) next_irq_temp[FLG_INT_HIGH] = 1'b1;
          if (is_below) next_irq_temp[FLG_INT_LOW] = 1'b1;
        end
        if (tvo_enable[0]) begin
          next_dac_int    = tvo_map(result, int_tvo_offset, tvo_ten_bit);
          next_dac_upd[0] = 1'b1;
        end
      end else begin
        next_low_ext[EXT_LSB_POS +: 2] = result[1:0];
        next_ext_hi = result[9:2];
        if (!irq_mask[MSK_EXT]) begin
          if (is_above) next_irq_temp[FLG_EXT_HIGH] = 1'b1;
          if (is_below) next_irq_temp[FLG_EXT_LOW] = 1'b1;
        end
        if (tvo_enable[1]) begin
          next_dac_ext    = tvo_map(result, ext_tvo_offset, tvo_ten_bit);
          next_dac_upd[1] = 1'b1;
        end
      end
    end
    // alert follows the stored flags
    next_alert = ((|irq_temp) || (|irq_sup)) ? alert_active_high : !alert_active_high;
    // read data, unmapped reads zero
    if (reg_req.rd) begin
      if (reg_req.addr == ADDR_IRQ_TEMP) next_rdata = irq_temp;
      else if (reg_req.addr == ADDR_INT_SUP_LO) next_rdata = low_is;
      else if (reg_req.addr == ADDR_EXT_LO) next_rdata = low_ext;
      else if (reg_req.addr == ADDR_SUP_HI) next_rdata = sup_hi;
      else if (reg_req.addr == ADDR_INT_HI) next_rdata = int_hi;
      else if (reg_req.addr == ADDR_EXT_HI) next_rdata = ext_hi;
      else if (reg_req.addr == ADDR_IRQ_SUP) next_rdata = irq_sup;
      else if (reg_req.addr == ADDR_MEAS_CTRL) next_rdata = ctrl;
      else next_rdata = 8'h00;
    end
  end

  // register file registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl         <= CTRL_RESET;
      irq_temp     <= 8'h00;
      irq_sup      <= 8'h00;
      low_is       <= 8'h00;
      low_ext      <= 8'h00;
      sup_hi       <= 8'h00;
      int_hi       <= 8'h00;
      ext_hi       <= 8'h00;
      reg_rdata    <= 8'h00;
      alert        <= 1'b0;
      dac_int_code <= 10'h000;
      dac_ext_code <= 10'h000;
      dac_update   <= 2'b00;
      adc_chan     <= 2'b00;
      adc_sample   <= 1'b0;
      adc_reset    <= 1'b1;
    end else begin
      ctrl         <= next_ctrl;
      irq_temp     <= next_irq_temp;
      irq_sup      <= next_irq_sup;
      low_is       <= next_low_is;
      low_ext      <= next_low_ext;
      sup_hi       <= next_sup_hi;
      int_hi       <= next_int_hi;
      ext_hi       <= next_ext_hi;
      reg_rdata    <= next_rdata;
      alert        <= next_alert;
      dac_int_code <= next_dac_int;
      dac_ext_code <= next_dac_ext;
      dac_update   <= next_dac_upd;
      adc_chan     <= next_chan;
      adc_sample   <= next_sample_q;
      adc_reset    <= (next_state == ST_IDLE);
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_abort_idle: assert property (serial_busy |=> state == ST_IDLE ##0 adc_reset)
    else $error("serial activity did not abort conversion");
  chk_restart_after: assert property (
    $fell(serial_busy) && monitor_en && !$past(rst) |=> state == ST_CONV && !adc_reset)
    else $error("conversion did not restart after serial transfer");
  chk_single_chan: assert property (
    state == ST_STORE && ctrl[CTRL_SINGLE] && !serial_busy && monitor_en
    |=> chan == sel_chan($past(ctrl)))
    else $error("single mode left the selected channel");
  chk_rr_order: assert property (
    state == ST_STORE && !ctrl[CTRL_SINGLE] && !serial_busy && monitor_en
    && chan == CH_SUPPLY |=> chan == CH_INT ##1 chan == CH_INT)
    else $error("round robin did not step from supply to internal");
  chk_avg_count: assert property (
    state == ST_CONV ##1 state == ST_STORE && !$past(ctrl[CTRL_AVG_OFF])
    |-> $past(nsamp) == AVG_LOG2'(AVG_SAMPLES - 1))
    else $error("result stored before all samples were taken");
  chk_temp_flag: assert property (
    state == ST_STORE && !serial_busy && chan == CH_INT && !irq_mask[MSK_INT]
    && $signed(result) > $signed(int_limits.high) |=> irq_temp[FLG_INT_HIGH])
    else $error("internal high flag not set");
  chk_sup_atomic: assert property (
    state == ST_STORE && !serial_busy && chan == CH_SUPPLY
    |=> {sup_hi, low_is[SUP_LSB_POS +: 2]} == $past(result))
    else $error("supply bytes not written as one update");
  chk_flag_sticky: assert property (
    !(reg_req.rd && reg_req.addr == ADDR_IRQ_TEMP)
    |=> (irq_temp & $past(irq_temp)) == $past(irq_temp))
    else $error("temperature flag dropped without a read");
  chk_alert_level: assert property (
    (irq_temp != 8'h00) && $stable(irq_temp) && $stable(alert_active_high)
    |=> alert == $past(alert_active_high))
    else $error("alert not at its active level");
  chk_tvo_sat: assert property (
    dac_update[0] && !$past(tvo_ten_bit) |-> dac_int_code[9:8] == 2'b00)
    else $error("eight bit thermal code exceeded its range");

  cov_rr_pass: cover property (state == ST_STORE && chan == CH_EXT && !ctrl[CTRL_SINGLE]);
  cov_single_sup: cover property (state == ST_STORE && chan == CH_SUPPLY && ctrl[CTRL_SINGLE]);
  cov_abort: cover property (state == ST_CONV ##1 serial_busy);
  cov_alert: cover property ($rose(|irq_sup));
endmodule // tsm_sequencer
`default_nettype wire
